// ==== hdl/pbcd_pin_cell.sv ====
`timescale 1ns/1ps
// ============================================================
// one pin: override selection and registered pad controls
module pbcd_pin_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // ordinary port settings
  input  wire logic pu_port,
  input  wire logic dir_port,
  input  wire logic out_port,
  input  wire logic die_port,
  // override enables and values
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic dir_override_en,
  input  wire logic dir_override_val,
  input  wire logic outval_override_en,
  input  wire logic outval_override_val,
  input  wire logic input_en_override_en,
  input  wire logic input_en_override_val,
  // resolved pad controls
  output      logic pu_out,
  output      logic oe_n,
  output      logic out_val,
  output      logic in_en
);

  // select override value or port setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_out  <= pbcd_pkg::RST_PULLUP;
      oe_n    <= pbcd_pkg::RST_OE_N;
      out_val <= pbcd_pkg::RST_OUT;
      in_en   <= pbcd_pkg::RST_IN_EN;
    end else begin
      pu_out  <= pullup_override_en ? pullup_override_val : pu_port;
      oe_n    <= ~(dir_override_en ? dir_override_val : dir_port);
      out_val <= outval_override_en ? outval_override_val : out_port;
      in_en   <= input_en_override_en ? input_en_override_val : die_port;
    end
  end

endmodule

// ==== hdl/pbcd_pkg.sv ====
package pbcd_pkg;

  // ==========================================================
  // pin geometry
  localparam int PORT_W    = 8;
  localparam int NUM_PINS  = 24;
  localparam int BASE_B    = 0;
  localparam int BASE_C    = 8;
  localparam int BASE_D    = 16;

  // ==========================================================
  // port b pin roles
  localparam int PIN_SS    = 0;
  localparam int PIN_SCK   = 1;
  localparam int PIN_MOSI  = 2;
  localparam int PIN_MISO  = 3;
  localparam int PIN_T0A   = 4;
  localparam int PIN_T1A   = 5;
  localparam int PIN_T1B   = 6;
  localparam int PIN_T2A   = 7;
  localparam int PCSRC_LO  = 8;
  localparam int PCSRC_HI  = 15;

  // ==========================================================
  // port d pin roles
  localparam int PIN_IRQ0  = 1;
  localparam int PIN_CAP1  = 0;

  // ==========================================================
  // lcd segment numbering
  localparam int LINE_LO     = 5;
  localparam int LINE_HI     = 22;
  localparam int LINE_C_TOP  = 12;
  localparam int LINE_D_BASE = 15;
  localparam int LINE_IRQ0   = 21;
  localparam int LINE_CAP1   = 22;

  // ==========================================================
  // reset values of pin controls
  localparam logic RST_PULLUP = 1'h0;
  localparam logic RST_OE_N   = 1'h1;
  localparam logic RST_OUT    = 1'h0;
  localparam logic RST_IN_EN  = 1'h0;
  localparam logic RST_SYNC   = 1'h0;

endpackage

// ==== hdl/pbcd_port_override.sv ====
`timescale 1ns/1ps
// ============================================================
// alternate function override for ports b and c, with port d taps and segment drive
module pbcd_port_override (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // port output and direction bits
  input  wire logic [7:0]  port_b_out,
  input  wire logic [7:0]  port_b_dir,
  input  wire logic [7:0]  port_c_out,
  input  wire logic [7:0]  port_c_dir,
  input  wire logic [7:0]  port_d_out,
  input  wire logic [7:0]  port_d_dir,
  input  wire logic        global_pullup_disable,
  // spi controls and data
  input  wire logic        spi_enable_bit,
  input  wire logic        master_select_bit,
  input  wire logic        spi_master_out,
  input  wire logic        spi_slave_out,
  input  wire logic        spi_sck_out,
  // timer compare outputs
  input  wire logic        timer0_compare_a_out,
  input  wire logic        timer0_compare_a_en,
  input  wire logic        timer1_compare_a_out,
  input  wire logic        timer1_compare_a_en,
  input  wire logic        timer1_compare_b_out,
  input  wire logic        timer1_compare_b_en,
  input  wire logic        timer2_compare_a_out,
  input  wire logic        timer2_compare_a_en,
  // pin change controls
  input  wire logic [7:0]  pin_change_mask,
  input  wire logic        pin_change_group1_en,
  // lcd controls and segment levels
  input  wire logic        lcd_drive_enable,
  input  wire logic [17:0] lcd_segment_line,
  // pad inputs
  input  wire logic [7:0]  pad_b_in,
  input  wire logic [7:0]  pad_c_in,
  input  wire logic [7:0]  pad_d_in,
  // pad controls
  output      logic [7:0]  pad_b_out,
  output      logic [7:0]  pad_b_oe_n,
  output      logic [7:0]  pad_b_pullup,
  output      logic [7:0]  pad_c_out,
  output      logic [7:0]  pad_c_oe_n,
  output      logic [7:0]  pad_c_pullup,
  output      logic [7:0]  pad_d_out,
  output      logic [7:0]  pad_d_oe_n,
  output      logic [7:0]  pad_d_pullup,
  // segment drive per pin
  output      logic [7:0]  lcd_c_drive,
  output      logic [7:0]  lcd_d_drive,
  // digital inputs back to the port
  output      logic [7:0]  port_b_in,
  output      logic [7:0]  port_c_in,
  output      logic [7:0]  port_d_in,
  // peripheral inputs
  output      logic        spi_slave_active,
  output      logic        spi_ss_in,
  output      logic        spi_master_in,
  output      logic        spi_slave_in,
  output      logic        spi_sck_in,
  output      logic [7:0]  pin_change_src,
  output      logic        ext_irq_zero_input,
  output      logic        capture_one_input
);

  // ==========================================================
  // flattened per-pin vectors, b at 0, c at 8, d at 16
  logic [23:0] pu_port;
  logic [23:0] dir_port;
  logic [23:0] out_port;
  logic [23:0] die_port;
  logic [23:0] pullup_override_en;
  logic [23:0] pullup_override_val;
  logic [23:0] dir_override_en;
  logic [23:0] dir_override_val;
  logic [23:0] outval_override_en;
  logic [23:0] outval_override_val;
  logic [23:0] input_en_override_en;
  logic [23:0] input_en_override_val;
  logic [23:0] pin_pullup;
  logic [23:0] pin_oe_n;
  logic [23:0] pin_out;
  logic [23:0] pin_in_en;
  logic [23:0] pad_sync;
  logic [23:0] next_din;
  logic        spi_slave_mode;
  logic        spi_master_mode;
  logic        pu_allow;

  assign spi_slave_mode  = spi_enable_bit & ~master_select_bit;
  assign spi_master_mode = spi_enable_bit & master_select_bit;
  assign pu_allow        = ~global_pullup_disable;

  // ==========================================================
  // ordinary port settings
  always_comb begin
    dir_port = {port_d_dir, port_c_dir, port_b_dir};
    out_port = {port_d_out, port_c_out, port_b_out};
    pu_port  = out_port & ~dir_port & {24{pu_allow}};
    die_port = {24{1'h1}};
  end

  // ==========================================================
  // port b override table
  always_comb begin
    pullup_override_en[7:0]    = 8'h00;
    pullup_override_val[7:0]   = 8'h00;
    dir_override_en[7:0]       = 8'h00;
    dir_override_val[7:0]      = 8'h00;
    outval_override_en[7:0]    = 8'h00;
    outval_override_val[7:0]   = 8'h00;
    // slave select forced input in slave mode only
    pullup_override_en[pbcd_pkg::PIN_SS]  = spi_slave_mode;
    pullup_override_val[pbcd_pkg::PIN_SS] = port_b_out[pbcd_pkg::PIN_SS] & pu_allow;
    dir_override_en[pbcd_pkg::PIN_SS]     = spi_slave_mode;
    // serial clock: input as slave, generated clock as master
    pullup_override_en[pbcd_pkg::PIN_SCK]  = spi_slave_mode;
    pullup_override_val[pbcd_pkg::PIN_SCK] = port_b_out[pbcd_pkg::PIN_SCK] & pu_allow;
    dir_override_en[pbcd_pkg::PIN_SCK]     = spi_slave_mode;
    outval_override_en[pbcd_pkg::PIN_SCK]  = spi_master_mode;
    outval_override_val[pbcd_pkg::PIN_SCK] = spi_sck_out;
    // master-out slave-in line
    pullup_override_en[pbcd_pkg::PIN_MOSI]  = spi_slave_mode;
    pullup_override_val[pbcd_pkg::PIN_MOSI] = port_b_out[pbcd_pkg::PIN_MOSI] & pu_allow;
    dir_override_en[pbcd_pkg::PIN_MOSI]     = spi_slave_mode;
    outval_override_en[pbcd_pkg::PIN_MOSI]  = spi_master_mode;
    outval_override_val[pbcd_pkg::PIN_MOSI] = spi_master_out;
    // master-in slave-out line
    pullup_override_en[pbcd_pkg::PIN_MISO]  = spi_master_mode;
    pullup_override_val[pbcd_pkg::PIN_MISO] = port_b_out[pbcd_pkg::PIN_MISO] & pu_allow;
    dir_override_en[pbcd_pkg::PIN_MISO]     = spi_master_mode;
    outval_override_en[pbcd_pkg::PIN_MISO]  = spi_slave_mode;
    outval_override_val[pbcd_pkg::PIN_MISO] = spi_slave_out;
    // compare outputs replace the output value only
    outval_override_en[pbcd_pkg::PIN_T0A]  = timer0_compare_a_en;
    outval_override_val[pbcd_pkg::PIN_T0A] = timer0_compare_a_out;
    outval_override_en[pbcd_pkg::PIN_T1A]  = timer1_compare_a_en;
    outval_override_val[pbcd_pkg::PIN_T1A] = timer1_compare_a_out;
    outval_override_en[pbcd_pkg::PIN_T1B]  = timer1_compare_b_en;
    outval_override_val[pbcd_pkg::PIN_T1B] = timer1_compare_b_out;
    outval_override_en[pbcd_pkg::PIN_T2A]  = timer2_compare_a_en;
    outval_override_val[pbcd_pkg::PIN_T2A] = timer2_compare_a_out;
  end

  // pin change sources keep the digital input on
  always_comb begin
    input_en_override_en[7:0]  = pin_change_mask & {8{pin_change_group1_en}};
    input_en_override_val[7:0] = 8'hff;
  end

  // ==========================================================
  // port c override table: lcd takes every pin
  always_comb begin
    pullup_override_en[15:8]    = {8{lcd_drive_enable}};
    pullup_override_val[15:8]   = 8'h00;
    dir_override_en[15:8]       = {8{lcd_drive_enable}};
    dir_override_val[15:8]      = 8'h00;
    outval_override_en[15:8]    = 8'h00;
    outval_override_val[15:8]   = 8'h00;
    input_en_override_en[15:8]  = {8{lcd_drive_enable}};
    input_en_override_val[15:8] = 8'h00;
  end

  // ==========================================================
  // port d: no override conditions, plain port behaviour
  always_comb begin
    pullup_override_en[23:16]    = 8'h00;
    pullup_override_val[23:16]   = 8'h00;
    dir_override_en[23:16]       = 8'h00;
    dir_override_val[23:16]      = 8'h00;
    outval_override_en[23:16]    = 8'h00;
    outval_override_val[23:16]   = 8'h00;
    input_en_override_en[23:16]  = 8'h00;
    input_en_override_val[23:16] = 8'h00;
  end

  // ==========================================================
  // one override cell per pin
  for (genvar i = 0; i < pbcd_pkg::NUM_PINS; i++) begin : g_pin
    pbcd_pin_cell u_cell (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .pu_port               (pu_port[i]),
      .dir_port              (dir_port[i]),
      .out_port              (out_port[i]),
      .die_port              (die_port[i]),
      .pullup_override_en    (pullup_override_en[i]),
      .pullup_override_val   (pullup_override_val[i]),
      .dir_override_en       (dir_override_en[i]),
      .dir_override_val      (dir_override_val[i]),
      .outval_override_en    (outval_override_en[i]),
      .outval_override_val   (outval_override_val[i]),
      .input_en_override_en  (input_en_override_en[i]),
      .input_en_override_val (input_en_override_val[i]),
      .pu_out                (pin_pullup[i]),
      .oe_n                  (pin_oe_n[i]),
      .out_val               (pin_out[i]),
      .in_en                 (pin_in_en[i])
    );
  end

  // pad controls come straight from the cell flops
  assign pad_b_out    = pin_out[7:0];
  assign pad_b_oe_n   = pin_oe_n[7:0];
  assign pad_b_pullup = pin_pullup[7:0];
  assign pad_c_out    = pin_out[15:8];
  assign pad_c_oe_n   = pin_oe_n[15:8];
  assign pad_c_pullup = pin_pullup[15:8];
  assign pad_d_out    = pin_out[23:16];
  assign pad_d_oe_n   = pin_oe_n[23:16];
  assign pad_d_pullup = pin_pullup[23:16];

  // ==========================================================
  // pad input synchronisation
  pbcd_sync2 #(
    .WIDTH (pbcd_pkg::NUM_PINS)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({pad_d_in, pad_c_in, pad_b_in}),
    .sync_out (pad_sync)
  );

  // gate synchronised pads by the resolved input enable
  assign next_din = pad_sync & pin_in_en;

  // digital input readback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_in <= 8'h00;
      port_c_in <= 8'h00;
      port_d_in <= 8'h00;
    end else begin
      port_b_in <= next_din[7:0];
      port_c_in <= next_din[15:8];
      port_d_in <= next_din[23:16];
    end
  end

  // ==========================================================
  // spi input taps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_ss_in        <= 1'h1;
      spi_slave_active <= 1'h0;
      spi_master_in    <= 1'h0;
      spi_slave_in     <= 1'h0;
      spi_sck_in       <= 1'h0;
    end else begin
      spi_ss_in        <= next_din[pbcd_pkg::PIN_SS];
      spi_slave_active <= spi_slave_mode & ~next_din[pbcd_pkg::PIN_SS];
      spi_master_in    <= next_din[pbcd_pkg::PIN_MISO];
      spi_slave_in     <= next_din[pbcd_pkg::PIN_MOSI];
      spi_sck_in       <= next_din[pbcd_pkg::PIN_SCK];
    end
  end

  // pin change sources 8..15 from port b
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_src <= 8'h00;
    end else begin
      pin_change_src <= next_din[7:0];
    end
  end

  // external interrupt 0 and capture inputs from port d
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_zero_input <= 1'h0;
      capture_one_input  <= 1'h0;
    end else begin
      ext_irq_zero_input <= next_din[pbcd_pkg::BASE_D + pbcd_pkg::PIN_IRQ0];
      capture_one_input  <= next_din[pbcd_pkg::BASE_D + pbcd_pkg::PIN_CAP1];
    end
  end

  // ==========================================================
  // segment routing, levels indexed from segment 5
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcd_c_drive <= 8'h00;
      lcd_d_drive <= 8'h00;
    end else begin
      for (int i = 0; i < pbcd_pkg::PORT_W; i++) begin
        // c0 carries 12, c7 carries 5
        lcd_c_drive[i] <= lcd_drive_enable &
          lcd_segment_line[pbcd_pkg::LINE_C_TOP - pbcd_pkg::LINE_LO - i];
      end
      for (int i = 2; i < pbcd_pkg::PORT_W; i++) begin
        // d7 carries 15, d2 carries 20
        lcd_d_drive[i] <= lcd_drive_enable &
          lcd_segment_line[pbcd_pkg::LINE_D_BASE - pbcd_pkg::LINE_LO + 7 - i];
      end
      lcd_d_drive[pbcd_pkg::PIN_IRQ0] <= lcd_drive_enable &
        lcd_segment_line[pbcd_pkg::LINE_IRQ0 - pbcd_pkg::LINE_LO];
      lcd_d_drive[pbcd_pkg::PIN_CAP1] <= lcd_drive_enable &
        lcd_segment_line[pbcd_pkg::LINE_CAP1 - pbcd_pkg::LINE_LO];
    end
  end

endmodule

// ==== hdl/pbcd_sync2.sv ====
`timescale 1ns/1ps
// ============================================================
// two flop synchroniser for pad inputs
module pbcd_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // first stage read only by second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= {WIDTH{pbcd_pkg::RST_SYNC}};
      sync_out <= {WIDTH{pbcd_pkg::RST_SYNC}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ==== tb/pbcd_pin_side.sv ====
`timescale 1ns/1ps
// ==========================================================
// far side of one port: outside drivers, pull-ups, float
module pbcd_pin_side (
  // clock
  input  wire logic       clk,
  // pad controls from the block
  input  wire logic [7:0] out_val,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pu_en,
  // outside driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // resolved pad level
  output      logic [7:0] level
);
  logic [7:0] flt = 8'h55;

  // undriven lines wander so no stale level survives
  always_ff @(posedge clk) begin
    flt <= ~flt;
  end

  // block drive wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n[i]) level[i] = out_val[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else level[i] = pu_en[i] | flt[i];
    end
  end
endmodule

// ==== tb/pbcd_port_override_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================
// checker on the override block's ports
module pbcd_port_override_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // controls seen by the block
  input wire logic [7:0]  port_b_out,
  input wire logic [7:0]  port_b_dir,
  input wire logic [7:0]  port_c_dir,
  input wire logic        global_pullup_disable,
  input wire logic        spi_enable_bit,
  input wire logic        master_select_bit,
  input wire logic        spi_master_out,
  input wire logic        spi_slave_out,
  input wire logic        spi_sck_out,
  input wire logic        timer0_compare_a_out,
  input wire logic        timer0_compare_a_en,
  input wire logic        lcd_drive_enable,
  input wire logic [17:0] lcd_segment_line,
  input wire logic [7:0]  pad_b_in,
  // outputs of the block
  input wire logic [7:0]  pad_b_out,
  input wire logic [7:0]  pad_b_oe_n,
  input wire logic [7:0]  pad_b_pullup,
  input wire logic [7:0]  pad_c_oe_n,
  input wire logic [7:0]  pad_c_pullup,
  input wire logic [7:0]  lcd_c_drive,
  input wire logic [7:0]  lcd_d_drive,
  input wire logic        spi_slave_active,
  input wire logic [7:0]  pin_change_src
);
  logic slv;
  logic mst;

  // ==========================================================
  // spi mode decode
  assign slv = spi_enable_bit & ~master_select_bit;
  assign mst = spi_enable_bit & master_select_bit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // sequences
  sequence s_pad_steady;
    $stable(pad_b_in)[*3];
  endsequence
  sequence s_selected;
    (slv && !pad_b_in[0])[*5];
  endsequence

  // ==========================================================
  // properties
  property p_slave_pins;
    slv |=> pad_b_oe_n[2:0] == 3'h7 && pad_b_out[3] == $past(spi_slave_out)
      && pad_b_pullup[0] == $past(port_b_out[0] & ~global_pullup_disable);
  endproperty
  a_slave_pins: assert property (p_slave_pins)
    else $error("slave mode pin controls wrong");
  property p_master_pins;
    mst |=> pad_b_oe_n[0] == !$past(port_b_dir[0])
      && pad_b_out[2:0] == $past({spi_master_out, spi_sck_out, port_b_out[0]});
  endproperty
  a_master_pins: assert property (p_master_pins)
    else $error("master mode pin controls wrong");
  property p_compare;
    1'b1 |=> pad_b_out[4] == ($past(timer0_compare_a_en) ?
      $past(timer0_compare_a_out) : $past(port_b_out[4]));
  endproperty
  a_compare: assert property (p_compare)
    else $error("b4 output value wrong");
  property p_lcd_c;
    lcd_drive_enable |=> pad_c_oe_n == 8'hff && pad_c_pullup == 8'h00;
  endproperty
  a_lcd_c: assert property (p_lcd_c)
    else $error("port c not released to segments");
  property p_port_c;
    !lcd_drive_enable |=> pad_c_oe_n == ~$past(port_c_dir);
  endproperty
  a_port_c: assert property (p_port_c)
    else $error("port c direction wrong");
  property p_seg_c;
    lcd_drive_enable |=> lcd_c_drive == $past({lcd_segment_line[0], lcd_segment_line[1],
      lcd_segment_line[2], lcd_segment_line[3], lcd_segment_line[4],
      lcd_segment_line[5], lcd_segment_line[6], lcd_segment_line[7]});
  endproperty
  a_seg_c: assert property (p_seg_c)
    else $error("port c segment order wrong");
  property p_seg_d;
    lcd_drive_enable |=> lcd_d_drive == $past({lcd_segment_line[10], lcd_segment_line[11],
      lcd_segment_line[12], lcd_segment_line[13], lcd_segment_line[14],
      lcd_segment_line[15], lcd_segment_line[16], lcd_segment_line[17]});
  endproperty
  a_seg_d: assert property (p_seg_d)
    else $error("port d segment order wrong");
  property p_pc_src;
    s_pad_steady |=> pin_change_src == $past(pad_b_in);
  endproperty
  a_pc_src: assert property (p_pc_src)
    else $error("pin change taps wrong");
  property p_selected;
    s_selected |=> spi_slave_active;
  endproperty
  a_selected: assert property (p_selected)
    else $error("slave not active while selected");
endmodule

bind pbcd_port_override pbcd_port_override_monitor u_mon (.*);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the port override block
module testbench;
  logic        clk, rst_n, global_pullup_disable, spi_enable_bit, master_select_bit;
  logic        spi_master_out, spi_slave_out, spi_sck_out, pin_change_group1_en;
  logic        lcd_drive_enable, spi_slave_active, spi_ss_in, spi_master_in;
  logic        spi_slave_in, spi_sck_in, ext_irq_zero_input, capture_one_input;
  logic        timer0_compare_a_out, timer0_compare_a_en, timer1_compare_a_out;
  logic        timer1_compare_a_en, timer1_compare_b_out, timer1_compare_b_en;
  logic        timer2_compare_a_out, timer2_compare_a_en;
  logic [7:0]  port_b_out, port_b_dir, port_c_out, port_c_dir, port_d_out, port_d_dir;
  logic [7:0]  pin_change_mask, pad_b_in, pad_c_in, pad_d_in, pin_change_src;
  logic [7:0]  pad_b_out, pad_b_oe_n, pad_b_pullup, pad_c_out, pad_c_oe_n, pad_c_pullup;
  logic [7:0]  pad_d_out, pad_d_oe_n, pad_d_pullup, lcd_c_drive, lcd_d_drive;
  logic [7:0]  port_b_in, port_c_in, port_d_in, exp_c, exp_d;
  logic [7:0]  ext_en_b, ext_val_b, ext_en_c, ext_val_c, ext_en_d, ext_val_d;
  logic [17:0] lcd_segment_line;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // ==========================================================
  // design and far side of each port
  pbcd_port_override dut (.*);
  pbcd_pin_side side_b (.clk(clk), .out_val(pad_b_out), .oe_n(pad_b_oe_n),
    .pu_en(pad_b_pullup), .ext_en(ext_en_b), .ext_val(ext_val_b), .level(pad_b_in));
  pbcd_pin_side side_c (.clk(clk), .out_val(pad_c_out), .oe_n(pad_c_oe_n),
    .pu_en(pad_c_pullup), .ext_en(ext_en_c), .ext_val(ext_val_c), .level(pad_c_in));
  pbcd_pin_side side_d (.clk(clk), .out_val(pad_d_out), .oe_n(pad_d_oe_n),
    .pu_en(pad_d_pullup), .ext_en(ext_en_d), .ext_val(ext_val_d), .level(pad_d_in));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================
  // tasks
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    {port_b_out, port_b_dir, port_c_out, port_c_dir, port_d_out, port_d_dir} = '0;
    {pin_change_mask, lcd_segment_line, ext_en_b, ext_val_b, ext_val_d} = '0;
    {global_pullup_disable, spi_enable_bit, master_select_bit, spi_master_out,
     spi_slave_out, spi_sck_out, pin_change_group1_en, lcd_drive_enable} = '0;
    {timer0_compare_a_out, timer0_compare_a_en, timer1_compare_a_out, timer1_compare_a_en,
     timer1_compare_b_out, timer1_compare_b_en, timer2_compare_a_out,
     timer2_compare_a_en} = '0;
    {ext_en_c, ext_val_c, ext_en_d} = 24'hffffff;
    repeat (5) @(posedge clk);
    #1;
    chk(pad_b_oe_n, 8'hff);
    chk(pad_c_oe_n, 8'hff);
    chk({7'h00, spi_ss_in}, 8'h01);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // ordinary port settings
    @(posedge clk);
    port_b_dir <= 8'h0f;
    port_b_out <= 8'ha5;
    port_c_dir <= 8'h33;
    port_c_out <= 8'h5a;
    port_d_dir <= 8'h3c;
    port_d_out <= 8'hc3;
    settle(1);
    chk(pad_b_oe_n, 8'hf0);
    chk(pad_b_pullup, 8'ha0);
    chk(pad_c_pullup, 8'h48);
    chk(pad_d_out, 8'hc3);
    chk(pad_c_out, 8'h5a);
    chk(pad_c_oe_n, 8'hcc);
    chk(pad_d_oe_n, 8'hc3);
    chk(pad_d_pullup, 8'hc3);
    @(posedge clk);
    global_pullup_disable <= 1'b1;
    settle(1);
    chk(pad_b_pullup, 8'h00);
    // spi slave selected by the outside master
    @(posedge clk);
    global_pullup_disable <= 1'b0;
    spi_enable_bit <= 1'b1;
    port_b_dir <= 8'hff;
    port_b_out <= 8'h05;
    spi_slave_out <= 1'b1;
    spi_sck_out <= 1'b1;
    pin_change_mask <= 8'hff;
    pin_change_group1_en <= 1'b1;
    ext_en_b <= 8'h07;
    ext_val_b <= 8'h04;
    settle(5);
    chk(pad_b_oe_n, 8'h07);
    chk(pad_b_out, 8'h0d);
    chk(pad_b_pullup, 8'h05);
    chk(pin_change_src, 8'h0c);
    chk(port_b_in, 8'h0c);
    chk({4'h0, spi_slave_active, spi_ss_in, spi_slave_in, spi_sck_in}, 8'h0a);
    @(posedge clk);
    ext_val_b <= 8'h05;
    settle(5);
    chk({7'h00, spi_slave_active}, 8'h00);
    // spi master
    @(posedge clk);
    master_select_bit <= 1'b1;
    port_b_dir <= 8'hfe;
    port_b_out <= 8'h01;
    spi_master_out <= 1'b1;
    ext_en_b <= 8'h09;
    ext_val_b <= 8'h08;
    settle(5);
    chk(pad_b_oe_n, 8'h09);
    chk(pad_b_out, 8'h07);
    chk({7'h00, spi_master_in}, 8'h01);
    @(posedge clk);
    port_b_dir <= 8'hff;
    settle(1);
    chk(pad_b_oe_n, 8'h08);
    // timer compare outputs on b7..b4
    @(posedge clk);
    spi_enable_bit <= 1'b0;
    port_b_out <= 8'hf0;
    {timer0_compare_a_en, timer1_compare_a_en, timer1_compare_b_en, timer2_compare_a_en} <= 4'hf;
    {timer0_compare_a_out, timer1_compare_a_out, timer1_compare_b_out,
     timer2_compare_a_out} <= 4'ha;
    settle(1);
    chk(pad_b_out, 8'h50);
    chk(pad_b_oe_n, 8'h00);
    @(posedge clk);
    {timer0_compare_a_en, timer1_compare_a_en, timer1_compare_b_en, timer2_compare_a_en} <= 4'h0;
    settle(1);
    chk(pad_b_out, 8'hf0);
    // lcd takes port c, segments driven on c and d
    @(posedge clk);
    lcd_drive_enable <= 1'b1;
    lcd_segment_line <= 18'h2a5b1;
    settle(5);
    for (int i = 0; i < 8; i++) begin
      exp_c[i] = lcd_segment_line[12 - i - 5];
      exp_d[i] = lcd_segment_line[22 - i - 5];
    end
    chk(lcd_c_drive, exp_c);
    chk(lcd_d_drive, exp_d);
    chk(pad_c_pullup, 8'h00);
    chk(port_c_in, 8'h00);
    @(posedge clk);
    lcd_drive_enable <= 1'b0;
    settle(1);
    chk(lcd_c_drive, 8'h00);
    chk(lcd_d_drive, 8'h00);
    // interrupt and capture taps on d1 and d0
    @(posedge clk);
    port_d_dir <= 8'h00;
    ext_val_d <= 8'h02;
    settle(5);
    chk({6'h00, ext_irq_zero_input, capture_one_input}, 8'h02);
    chk(port_d_in, 8'h02);
    @(posedge clk);
    ext_val_d <= 8'h01;
    settle(5);
    chk({6'h00, ext_irq_zero_input, capture_one_input}, 8'h01);
    chk(port_d_in, 8'h01);
    report_and_stop();
  end
endmodule
